// *** include/iaois_consts.svh ***
// opcode fields, reset values and timing counts for the instruction slice
`ifndef IAOIS_CONSTS_SVH
`define IAOIS_CONSTS_SVH

// ----------------------------------------------------------------------
// opcode layout
// ----------------------------------------------------------------------
`define IAOIS_INSTR_W      14        // instruction word width
`define IAOIS_OPC_HI       13        // top bit of the six-bit opcode
`define IAOIS_OPC_LO       8         // bottom bit of the opcode
`define IAOIS_DEST_BIT     7         // destination select bit
`define IAOIS_ADDR_HI      6         // top bit of the file address
`define IAOIS_LIT_HI       7         // top bit of the literal

`define IAOIS_OPC_INC      6'h0A     // increment file
`define IAOIS_OPC_INCSZ    6'h0F     // increment, skip on zero
`define IAOIS_OPC_ORL      6'h1A     // or literal into accumulator
`define IAOIS_OPC_ORW      6'h04     // or accumulator with file

`define IAOIS_DEST_ACC     1'b0      // result goes to accumulator
`define IAOIS_DEST_FILE    1'b1      // result goes back to file

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define IAOIS_ACC_RST      8'h00     // accumulator after reset
`define IAOIS_ADDR_RST     7'h00     // write address after reset
`define IAOIS_ONE          8'h01     // increment step
`define IAOIS_SKIP_CYCLES  2         // cycles spent by a taken skip

`endif

// *** include/iaois_pkg.sv ***
// shared types of the instruction slice
package iaois_pkg;

    // ------------------------------------------------------------------
    // decoded operation
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IAOIS_OP_NONE,                   // not handled by this slice
        IAOIS_OP_INC,                    // increment_file_op
        IAOIS_OP_INCSZ,                  // increment_skip_zero_op
        IAOIS_OP_ORL,                    // or_literal_into_acc_op
        IAOIS_OP_ORW                     // or_acc_with_file_op
    } iaois_op_t;

    // ------------------------------------------------------------------
    // sequencing state
    // ------------------------------------------------------------------
    typedef enum logic {
        IAOIS_ST_EXEC,                   // instructions execute normally
        IAOIS_ST_FILL                    // next one becomes a filler
    } iaois_state_t;

endpackage : iaois_pkg

// *** rtl/iaois_alu.sv ***
// result and zero detect for the four operations of the slice
`include "iaois_consts.svh"

module iaois_alu #(
    parameter int DATA_W = 8
) (
    input  wire iaois_pkg::iaois_op_t op,
    input  wire logic [DATA_W-1:0] acc,
    input  wire logic [DATA_W-1:0] file_data,
    input  wire logic [DATA_W-1:0] literal,
    output logic      [DATA_W-1:0] result,
    output logic                   is_zero
);

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    // both increments share one adder; the carry out is dropped on
    // purpose so FFh wraps to 00h
    wire logic [DATA_W-1:0] inc_sum = DATA_W'(file_data + DATA_W'(1));
    wire logic [DATA_W-1:0] orl_val = acc | literal;   // literal or
    wire logic [DATA_W-1:0] orw_val = acc | file_data; // file or

    // one result mux, selected by decoded operation
    always_comb begin
        case (op)
            iaois_pkg::IAOIS_OP_INC,
            iaois_pkg::IAOIS_OP_INCSZ: result = inc_sum;
            iaois_pkg::IAOIS_OP_ORL:   result = orl_val;
            iaois_pkg::IAOIS_OP_ORW:   result = orw_val;
            default:                   result = '0;
        endcase
    end

    // zero test on the full eight-bit result
    assign is_zero = (result == '0);

endmodule : iaois_alu

// *** rtl/iaois_top.sv ***
// decode and execution of the increment and or instructions
//
// Notes on behaviour
// RULE1: increment adds one, one cycle, updates zero
// RULE2: destination bit 0 accumulator, 1 file
// RULE3: increment-skip stores result, flags untouched
// RULE4: zero result turns next instruction into filler
// RULE5: seven-bit file address plus destination bit
// RULE6: literal or into accumulator, zero, one cycle
// RULE7: accumulator or file, per destination, zero
// RULE8: zero flag set exactly on all-zero result
`include "iaois_consts.svh"

module iaois_top #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic                     instr_valid,
    input  wire logic [`IAOIS_INSTR_W-1:0] instr,
    input  wire logic [DATA_W-1:0]        file_rd_data,
    output logic      [DATA_W-1:0]        acc_reg,
    output logic                          zero_flag_reg,
    output logic                          file_wr_en_reg,
    output logic      [ADDR_W-1:0]        file_wr_addr_reg,
    output logic      [DATA_W-1:0]        file_wr_data_reg,
    output logic                          done_reg,
    output logic                          skip_pending_reg,
    output logic                          filler_reg
);

    // ------------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------------
    wire logic [5:0]        opc     = instr[`IAOIS_OPC_HI:`IAOIS_OPC_LO];
    wire logic              dest    = instr[`IAOIS_DEST_BIT];
    // file address is the low seven bits, 00h to 7Fh
    wire logic [ADDR_W-1:0] f_addr  = instr[ADDR_W-1:0];      // see RULE5
    wire logic [DATA_W-1:0] literal = instr[`IAOIS_LIT_HI:0];

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    iaois_pkg::iaois_state_t state_reg;   // skip sequencing
    iaois_pkg::iaois_state_t state_next;  // next sequencing state
    iaois_pkg::iaois_op_t    op;          // decoded operation

    // the filler swallows whatever instruction follows a taken skip,
    // including ones this slice does not execute itself
    wire logic fill_now = instr_valid
                          && (state_reg == iaois_pkg::IAOIS_ST_FILL);
    wire logic exec_ok  = instr_valid && !fill_now;

    // opcode match; the literal form has no destination bit
    assign op = !exec_ok                      ? iaois_pkg::IAOIS_OP_NONE :
                (opc == `IAOIS_OPC_INC)       ? iaois_pkg::IAOIS_OP_INC :
                (opc == `IAOIS_OPC_INCSZ)     ? iaois_pkg::IAOIS_OP_INCSZ :
                (opc == `IAOIS_OPC_ORL)       ? iaois_pkg::IAOIS_OP_ORL :
                (opc == `IAOIS_OPC_ORW)       ? iaois_pkg::IAOIS_OP_ORW :
                                                iaois_pkg::IAOIS_OP_NONE;

    wire logic take_any  = (op != iaois_pkg::IAOIS_OP_NONE);
    wire logic take_incsz = (op == iaois_pkg::IAOIS_OP_INCSZ);
    wire logic take_orl  = (op == iaois_pkg::IAOIS_OP_ORL);
    // register forms route by the destination bit
    wire logic reg_form  = take_any && !take_orl;
    // every slice operation except the skipping increment moves zero
    wire logic z_update  = take_any && !take_incsz;           // see RULE3

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] alu_result;        // operation result
    logic              alu_zero;          // result is all zeros

    iaois_alu #(
        .DATA_W    (DATA_W)
    ) u_alu (
        .op        (op),
        .acc       (acc_reg),
        .file_data (file_rd_data),
        .literal   (literal),
        .result    (alu_result),
        .is_zero   (alu_zero)
    );

    // destination steering
    wire logic to_file = reg_form && (dest == `IAOIS_DEST_FILE); // see RULE2
    wire logic to_acc  = take_orl
                         || (reg_form && (dest == `IAOIS_DEST_ACC));

    wire logic [DATA_W-1:0] acc_next  = to_acc ? alu_result : acc_reg;
    // zero flag tracks the result only where the operation says so
    wire logic zero_next = z_update ? alu_zero : zero_flag_reg; // see RULE8

    // ------------------------------------------------------------------
    // skip sequencing
    // ------------------------------------------------------------------
    // a wrapped skipping increment arms the filler; the filler cycle
    // itself returns to normal, so the skip costs two valid instruction cycles
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            iaois_pkg::IAOIS_ST_EXEC: begin
                if (take_incsz && alu_zero) begin               // see RULE4
                    state_next = iaois_pkg::IAOIS_ST_FILL;
                end
            end
            iaois_pkg::IAOIS_ST_FILL: begin
                if (instr_valid) begin
                    state_next = iaois_pkg::IAOIS_ST_EXEC;
                end
            end
            default: state_next = iaois_pkg::IAOIS_ST_EXEC;
        endcase
    end

    // ------------------------------------------------------------------
    // architectural state
    // ------------------------------------------------------------------
    // accumulator, zero flag and sequencing state
    always_ff @(posedge clock) begin
        if (reset) begin
            acc_reg       <= `IAOIS_ACC_RST;
            zero_flag_reg <= 1'b0;
            state_reg     <= iaois_pkg::IAOIS_ST_EXEC;
        end else begin
            acc_reg       <= acc_next;                 // see RULE1
            zero_flag_reg <= zero_next;                // see RULE6
            state_reg     <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // file write port and status pulses
    // ------------------------------------------------------------------
    // write strobe is a one-cycle pulse; address and data hold
    always_ff @(posedge clock) begin
        if (reset) begin
            file_wr_en_reg   <= 1'b0;
            file_wr_addr_reg <= `IAOIS_ADDR_RST;
            file_wr_data_reg <= `IAOIS_ACC_RST;
            done_reg         <= 1'b0;
            filler_reg       <= 1'b0;
        end else begin
            file_wr_en_reg   <= to_file;               // see RULE7
            if (to_file) begin
                file_wr_addr_reg <= f_addr;            // see RULE5
                file_wr_data_reg <= alu_result;
            end
            done_reg         <= take_any;
            filler_reg       <= fill_now;              // see RULE4
        end
    end

    // mirror of the armed filler for the program sequencer
    assign skip_pending_reg = (state_reg == iaois_pkg::IAOIS_ST_FILL);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_inc_value:                                                // see RULE1
    assert property ((op == iaois_pkg::IAOIS_OP_INC) && !to_file |=>
        acc_reg == DATA_W'($past(file_rd_data) + `IAOIS_ONE) && done_reg)
    else $error("increment result wrong in accumulator");

    a_dest_file:                                                // see RULE2
    assert property (to_file |=> file_wr_en_reg
        && file_wr_data_reg == $past(alu_result)
        && acc_reg == $past(acc_reg))
    else $error("file destination not honoured");

    a_skip_flags:                                               // see RULE3
    assert property (take_incsz |=> $stable(zero_flag_reg))
    else $error("skipping increment changed zero flag");

    a_skip_fill:                                                // see RULE4
    assert property (take_incsz && alu_zero ##1 instr_valid[*1] |=>
        filler_reg && !done_reg && !file_wr_en_reg
        && $stable(acc_reg) && $stable(zero_flag_reg))
    else $error("instruction after wrapped skip not filled");

    a_no_skip:                                                  // see RULE4
    assert property (take_incsz && !alu_zero |=> !skip_pending_reg
        ##1 !filler_reg)
    else $error("skip taken on nonzero result");

    a_addr_field:                                               // see RULE5
    assert property (to_file |=> file_wr_addr_reg == $past(f_addr))
    else $error("file write address wrong");

    a_orl_value:                                                // see RULE6
    assert property (take_orl |=> acc_reg ==
        ($past(acc_reg) | $past(literal)) && !file_wr_en_reg)
    else $error("literal or result wrong");

    a_orw_value:                                                // see RULE7
    assert property ((op == iaois_pkg::IAOIS_OP_ORW) && !to_file |=>
        acc_reg == ($past(acc_reg) | $past(file_rd_data)))
    else $error("register or result wrong");

    a_zero_flag:                                                // see RULE8
    assert property (z_update |=>
        zero_flag_reg == ($past(alu_result) == '0))
    else $error("zero flag does not match result");

    // the checks below judge from the operands alone, not from the
    // adder or zero detect, so a broken datapath cannot hide behind itself
    a_wrap_zero:                                                // see RULE8
    assert property ((op == iaois_pkg::IAOIS_OP_INC)
        && (file_rd_data == '1) |=> zero_flag_reg)
    else $error("increment wrap did not set zero flag");

    a_inc_file:                                                 // see RULE1
    assert property (to_file && (take_incsz
        || (op == iaois_pkg::IAOIS_OP_INC)) |=>
        file_wr_data_reg == DATA_W'($past(file_rd_data) + `IAOIS_ONE))
    else $error("increment result wrong in file write");

    a_orw_file:                                                 // see RULE7
    assert property ((op == iaois_pkg::IAOIS_OP_ORW) && to_file |=>
        file_wr_data_reg == ($past(acc_reg) | $past(file_rd_data)))
    else $error("register or result wrong in file write");

endmodule : iaois_top

// *** sim/tb_inc_and_or_instruction_slice.sv ***
// self-checking testbench for the increment and or instruction slice
`include "iaois_consts.svh"

module tb_inc_and_or_instruction_slice;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clock        = 1'b0;   // 200 MHz core clock
    logic        reset        = 1'b1;   // synchronous, active high
    logic        instr_valid  = 1'b0;   // instruction offered
    logic [13:0] instr        = 14'h0000; // instruction word
    logic [7:0]  file_rd_data = 8'h00;  // addressed file contents
    logic [7:0]  acc_reg;               // accumulator
    logic        zero_flag_reg;         // zero flag
    logic        file_wr_en_reg;        // file write pulse
    logic [6:0]  file_wr_addr_reg;      // file write address
    logic [7:0]  file_wr_data_reg;      // file write data
    logic        done_reg;              // executed pulse
    logic        skip_pending_reg;      // next one becomes filler
    logic        filler_reg;            // swallowed pulse
    int          err_total    = 0;      // mismatches
    int          total_checks = 0;      // comparisons made
    int          cycle_count  = 0;      // cycles since start

    iaois_top i_dut (
        .clock            (clock),
        .reset            (reset),
        .instr_valid      (instr_valid),
        .instr            (instr),
        .file_rd_data     (file_rd_data),
        .acc_reg          (acc_reg),
        .zero_flag_reg    (zero_flag_reg),
        .file_wr_en_reg   (file_wr_en_reg),
        .file_wr_addr_reg (file_wr_addr_reg),
        .file_wr_data_reg (file_wr_data_reg),
        .done_reg         (done_reg),
        .skip_pending_reg (skip_pending_reg),
        .filler_reg       (filler_reg)
    );

    // clock: invert every half period
    always #2.5 clock = ~clock;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // one comparison, counted; case inequality so unknowns fail
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    // offer one instruction for one edge, then look after the answer
    task exec(input logic [13:0] ins, input logic [7:0] fd);
        @(posedge clock);
        instr        <= ins;
        file_rd_data <= fd;
        instr_valid  <= 1'b1;
        @(posedge clock);
        instr_valid  <= 1'b0;
        #1;
    endtask : exec

    // common outcome: accumulator, zero flag, done, write pulse
    task outc(input logic [7:0] a, input logic z, input logic dn,
              input logic we);
        chk(acc_reg, a);
        chk({7'h00, zero_flag_reg}, {7'h00, z});
        chk({7'h00, done_reg}, {7'h00, dn});
        chk({7'h00, file_wr_en_reg}, {7'h00, we});
    endtask : outc

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // literal or: zero result first, then the 9A | 35 case
    task t_or_literal;
        exec({`IAOIS_OPC_ORL, 8'h00}, 8'h00);
        outc(8'h00, 1'b1, 1'b1, 1'b0);
        exec({`IAOIS_OPC_ORL, 8'h9A}, 8'h00);
        outc(8'h9A, 1'b0, 1'b1, 1'b0);
        exec({`IAOIS_OPC_ORL, 8'h35}, 8'h00);
        outc(8'hBF, 1'b0, 1'b1, 1'b0);
    endtask : t_or_literal

    // increment to file with wrap, then to accumulator
    task t_increment;
        exec({`IAOIS_OPC_INC, 1'b1, 7'h7F}, 8'hFF);
        outc(8'hBF, 1'b1, 1'b1, 1'b1);
        chk({1'b0, file_wr_addr_reg}, 8'h7F);
        chk(file_wr_data_reg, 8'h00);
        exec({`IAOIS_OPC_INC, 1'b0, 7'h05}, 8'h41);
        outc(8'h42, 1'b0, 1'b1, 1'b0);
    endtask : t_increment

    // accumulator or file, both destinations and a zero result
    task t_or_file;
        exec({`IAOIS_OPC_INC, 1'b0, 7'h01}, 8'h90);
        exec({`IAOIS_OPC_ORW, 1'b0, 7'h05}, 8'h13);
        outc(8'h93, 1'b0, 1'b1, 1'b0);
        exec({`IAOIS_OPC_ORW, 1'b1, 7'h33}, 8'h04);
        outc(8'h93, 1'b0, 1'b1, 1'b1);
        chk({1'b0, file_wr_addr_reg}, 8'h33);
        chk(file_wr_data_reg, 8'h97);
        exec({`IAOIS_OPC_INC, 1'b0, 7'h01}, 8'hFF);
        exec({`IAOIS_OPC_INC, 1'b1, 7'h01}, 8'h00);
        exec({`IAOIS_OPC_ORW, 1'b0, 7'h02}, 8'h00);
        outc(8'h00, 1'b1, 1'b1, 1'b0);
    endtask : t_or_file

    // skip: flags untouched, no skip on nonzero, filler after a gap
    task t_skip;
        exec({`IAOIS_OPC_INCSZ, 1'b1, 7'h10}, 8'h41);
        outc(8'h00, 1'b1, 1'b1, 1'b1);
        chk(file_wr_data_reg, 8'h42);
        chk({7'h00, skip_pending_reg}, 8'h00);
        exec({`IAOIS_OPC_INC, 1'b1, 7'h01}, 8'h00);
        exec({`IAOIS_OPC_INCSZ, 1'b0, 7'h11}, 8'hFF);
        outc(8'h00, 1'b0, 1'b1, 1'b0);
        chk({7'h00, skip_pending_reg}, 8'h01);
        @(posedge clock);
        exec({`IAOIS_OPC_ORL, 8'h55}, 8'h00);
        outc(8'h00, 1'b0, 1'b0, 1'b0);
        chk({7'h00, filler_reg}, 8'h01);
        chk({7'h00, skip_pending_reg}, 8'h00);
        exec({`IAOIS_OPC_ORL, 8'h55}, 8'h00);
        outc(8'h55, 1'b0, 1'b1, 1'b0);
        chk({7'h00, filler_reg}, 8'h00);
    endtask : t_skip

    // back to back: wrapped skip, swallowed neighbour, then normal
    task t_back_to_back;
        @(posedge clock);
        instr        <= {`IAOIS_OPC_INCSZ, 1'b0, 7'h12};
        file_rd_data <= 8'hFF;
        instr_valid  <= 1'b1;
        @(posedge clock);
        instr        <= {`IAOIS_OPC_ORL, 8'hAA};
        file_rd_data <= 8'h00;
        #1;
        outc(8'h00, 1'b0, 1'b1, 1'b0);
        chk({7'h00, skip_pending_reg}, 8'h01);
        @(posedge clock);
        instr        <= {`IAOIS_OPC_ORL, 8'h0F};
        #1;
        outc(8'h00, 1'b0, 1'b0, 1'b0);
        chk({7'h00, filler_reg}, 8'h01);
        @(posedge clock);
        instr_valid  <= 1'b0;
        #1;
        outc(8'h0F, 1'b0, 1'b1, 1'b0);
        chk({7'h00, filler_reg}, 8'h00);
    endtask : t_back_to_back

    // foreign opcode leaves everything alone
    task t_refused;
        exec(14'h0385, 8'h00);
        outc(8'h55, 1'b0, 1'b0, 1'b0);
    endtask : t_refused

    // ------------------------------------------------------------------
    // closing report and hang guard
    // ------------------------------------------------------------------
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // runaway guard: the whole sequence needs well under 200 cycles
    always @(posedge clock) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 2000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // main sequence: three reset cycles, then every scenario
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        #1;
        outc(8'h00, 1'b0, 1'b0, 1'b0);
        t_or_literal();
        t_increment();
        t_or_file();
        t_skip();
        t_refused();
        t_back_to_back();
        tally_and_finish();
    end

endmodule : tb_inc_and_or_instruction_slice
